// *** fsla_cfg.svh ***
// Constants for the feedback selection and loop activation block
`ifndef FSLA_CFG_SVH
`define FSLA_CFG_SVH
`define FSLA_BIT_POS 0
`define FSLA_BIT_VEL 1
`define FSLA_BIT_COM 2
`define FSLA_SUB_CL_EN 0
`define FSLA_SUB_AUTO_ALIGN 4
`define FSLA_SUB_SLOW 7
`define FSLA_STAT_CL 15
`define FSLA_FIRST_SCAN 1
`define FSLA_ADDR_MASK0 8'h00
`define FSLA_ADDR_SUBMODE 8'h10
`define FSLA_ADDR_STATUS 8'h11
`define FSLA_ADDR_LOOPSEL 8'h12
`define FSLA_ADDR_SPEED 8'h13
`define FSLA_ADDR_THRESH 8'h14
`define FSLA_HYST_PCT 10
`define FSLA_PCT_FULL 100
`define FSLA_FILT_SHIFT 3
`define FSLA_SENS_NONE 8'hff
`endif

// *** fsla_pkg.sv ***
// Types for the feedback selection and loop activation block
package fsla_pkg;
  typedef enum logic [2:0]
  {
    FSLA_OPEN = 3'b000,
    FSLA_ALIGN = 3'b001,
    FSLA_CLOSED = 3'b010,
    FSLA_SLOW = 3'b011
  } fsla_mode_t;
endpackage : fsla_pkg

// *** fsla_mask_if.sv ***
// Interface carrying the assignment mask store access
interface fsla_mask_if #(parameter int NSENS = 4);
  logic we;
  logic [$clog2(NSENS)-1:0] waddr;
  logic [7:0] wdata;
  logic [7:0] q [NSENS];
  modport store (input we, input waddr, input wdata, output q);
  modport user (output we, output waddr, output wdata, input q);
endinterface : fsla_mask_if

// *** fsla_mask_store.sv ***
// Register store of the per-sensor feedback assignment masks
module fsla_mask_store #(
  parameter int NSENS = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Store port
  fsla_mask_if.store m
);
  logic [7:0] mem [NSENS];
  always_ff @(posedge sys_clk_i)
  begin
    for (int i = 0; i < NSENS; i++)
    begin
      if (rst_i)
        mem[i] <= 8'h00;
      else if (m.we && int'(m.waddr) == i)
        mem[i] <= m.wdata;
    end
  end
  assign m.q = mem;
endmodule : fsla_mask_store

// *** fsla_top.sv ***
// Feedback to loop assignment and closed loop activation
// Summary of operation
// - Mask bit 0 marks position source candidate
// - Mask bit 1 marks velocity source candidate
// - Mask bit 2 marks commutation source candidate
// - Entry 0 is sensorless; others physical order
// - Scan upward from sensor 1; first wins
// - Commutate from the better aligned sensor
// - No aligned sensor: open loop auto alignment
// - Closed loop needs enable; setup sets it
// - Absolute commutation sensor: closed at once
// - Encoder commutation: closed after first index
// - Auto alignment once per restart on enable
// - Enter operation enabled after alignment ends
// - Status bit 15 shows closed loop active while operation enabled
// - Slow speed only with encoder feedback
// - Speed is filtered position delta per cycle
// - Slow speed: constant current, error monitored
// - Slow speed needs closed loop and bit 7
// - Auto changeover with hysteresis band
// - Standstill runs in closed loop
//
// Decided for this implementation: strobed register access and the register addresses.
`include "fsla_cfg.svh"
module fsla_top #(
  parameter int NSENS = 4,
  parameter int SPW = 16,
  parameter int THRESH = 600
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Sensors
  input wire logic [NSENS-1:0] sens_abs_i,
  input wire logic [NSENS-1:0] sens_enc_i,
  input wire logic [NSENS-1:0] sens_aligned_i,
  input wire logic enc_index_i,
  input wire logic [SPW-1:0] enc_pos_i,
  input wire logic cycle_i,
  // Power state machine
  input wire logic op_req_i,
  input wire logic op_enabled_i,
  input wire logic setup_done_i,
  output logic op_grant_o,
  // Alignment run
  output logic align_run_o,
  input wire logic align_done_i,
  // Loop outputs
  output logic [7:0] pos_sel_o,
  output logic [7:0] vel_sel_o,
  output logic [7:0] com_sel_o,
  output logic closed_o,
  output logic slow_o,
  output logic const_current_o,
  output logic ferr_mon_o
);
  initial
  begin
    if (NSENS < 2 || NSENS > 8)
      $error("NSENS out of range");
    if (THRESH < 10)
      $error("THRESH too small");
  end

  localparam int AW = $clog2(NSENS);
  localparam logic [SPW-1:0] TH_HI =
    SPW'(THRESH + THRESH * `FSLA_HYST_PCT / `FSLA_PCT_FULL);
  localparam logic [SPW-1:0] TH_LO =
    SPW'(THRESH - THRESH * `FSLA_HYST_PCT / `FSLA_PCT_FULL);

  fsla_mask_if #(.NSENS(NSENS)) mif ();
  fsla_mask_store #(.NSENS(NSENS)) u_store (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .m(mif)
  );

  // Scan from the first physical sensor upward; sensorless is skipped
  function automatic logic [7:0] first_set(input logic [7:0] q [NSENS],
                                           input int b);
    logic [7:0] r;
    r = `FSLA_SENS_NONE;
    for (int i = NSENS - 1; i >= `FSLA_FIRST_SCAN; i--)
    begin
      if (q[i][b])
        r = 8'(i);
    end
    return r;
  endfunction : first_set

  logic [7:0] submode;
  logic index_seen;
  logic aligned_once;
  logic [7:0] next_com;
  logic com_ok;
  logic com_abs;
  logic com_need_align;
  logic [SPW-1:0] pos_prev;
  logic [SPW-1:0] speed_raw;
  logic [SPW-1:0] speed_abs;
  logic signed [SPW:0] speed_diff;
  logic [SPW-1:0] speed;
  logic above;
  logic enc_present;
  fsla_pkg::fsla_mode_t mode;
  fsla_pkg::fsla_mode_t next_mode;

  assign mif.we = wr_i && addr_i < 8'(NSENS);
  assign mif.waddr = AW'(addr_i);
  assign mif.wdata = wdata_i[7:0];

  // Position and velocity selection
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pos_sel_o <= `FSLA_SENS_NONE;
      vel_sel_o <= `FSLA_SENS_NONE;
    end
    else
    begin
      pos_sel_o <= first_set(mif.q, `FSLA_BIT_POS);
      vel_sel_o <= first_set(mif.q, `FSLA_BIT_VEL);
    end
  end

  // Commutation: an indexed encoder beats an aligned sensor
  always_comb
  begin
    next_com = `FSLA_SENS_NONE;
    com_ok = 1'b0;
    for (int i = NSENS - 1; i >= `FSLA_FIRST_SCAN; i--)
    begin
      if (mif.q[i][`FSLA_BIT_COM] && sens_aligned_i[i])
      begin
        next_com = 8'(i);
        com_ok = 1'b1;
      end
    end
    for (int i = NSENS - 1; i >= `FSLA_FIRST_SCAN; i--)
    begin
      if (mif.q[i][`FSLA_BIT_COM] && sens_enc_i[i] && index_seen)
      begin
        next_com = 8'(i);
        com_ok = 1'b1;
      end
    end
    if (!com_ok)
      next_com = first_set(mif.q, `FSLA_BIT_COM);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      com_sel_o <= `FSLA_SENS_NONE;
    else
      com_sel_o <= next_com;
  end

  assign com_abs = com_ok && next_com != `FSLA_SENS_NONE &&
                   sens_abs_i[next_com[AW-1:0]];
  assign com_need_align = !aligned_once &&
                          (submode[`FSLA_SUB_AUTO_ALIGN] || !com_ok);

  // Submode register; auto setup sets the closed loop enable itself
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      submode <= 8'h00;
    else
    begin
      if (wr_i && addr_i == `FSLA_ADDR_SUBMODE)
        submode <= wdata_i[7:0];
      if (setup_done_i)
        submode[`FSLA_SUB_CL_EN] <= 1'b1;
    end
  end

  // Index seen since restart
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      index_seen <= 1'b0;
    else if (enc_index_i)
      index_seen <= 1'b1;
  end

  // Alignment done once per restart
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      aligned_once <= 1'b0;
    else if (mode == fsla_pkg::FSLA_ALIGN && align_done_i)
      aligned_once <= 1'b1;
  end

  // Speed from position delta per control cycle, low-pass filtered
  // Arithmetic shift rounds down, so a stopped motor reads zero
  assign speed_raw = enc_pos_i - pos_prev;
  assign speed_abs = speed_raw[SPW-1] ? SPW'(-speed_raw) : speed_raw;
  assign speed_diff = $signed({1'b0, speed_abs}) - $signed({1'b0, speed});
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pos_prev <= '0;
      speed <= '0;
    end
    else if (cycle_i)
    begin
      pos_prev <= enc_pos_i;
      speed <= speed + SPW'(speed_diff >>> `FSLA_FILT_SHIFT);
    end
  end

  // Changeover with a band around the threshold
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      above <= 1'b1;
    else if (speed > TH_HI)
      above <= 1'b1;
    else if (speed < TH_LO)
      above <= 1'b0;
  end

  assign enc_present = |sens_enc_i[NSENS-1:1];

  // Loop mode
  always_comb
  begin
    next_mode = mode;
    case (mode)
      fsla_pkg::FSLA_OPEN:
      begin
        if (op_req_i && com_need_align)
          next_mode = fsla_pkg::FSLA_ALIGN;
        else if (submode[`FSLA_SUB_CL_EN] && com_ok &&
                 (com_abs || index_seen || aligned_once))
          next_mode = fsla_pkg::FSLA_CLOSED;
        else if (submode[`FSLA_SUB_CL_EN] && aligned_once)
          next_mode = fsla_pkg::FSLA_CLOSED;
      end
      fsla_pkg::FSLA_ALIGN:
      begin
        if (align_done_i)
          next_mode = submode[`FSLA_SUB_CL_EN] ?
                      fsla_pkg::FSLA_CLOSED : fsla_pkg::FSLA_OPEN;
      end
      fsla_pkg::FSLA_CLOSED:
      begin
        if (!submode[`FSLA_SUB_CL_EN])
          next_mode = fsla_pkg::FSLA_OPEN;
        else if (submode[`FSLA_SUB_SLOW] && enc_present &&
                 !above && speed != '0)
          next_mode = fsla_pkg::FSLA_SLOW;
      end
      fsla_pkg::FSLA_SLOW:
      begin
        if (!submode[`FSLA_SUB_CL_EN])
          next_mode = fsla_pkg::FSLA_OPEN;
        else if (!submode[`FSLA_SUB_SLOW] || !enc_present ||
                 above || speed == '0)
          next_mode = fsla_pkg::FSLA_CLOSED;
      end
      default:
        next_mode = fsla_pkg::FSLA_OPEN;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      mode <= fsla_pkg::FSLA_OPEN;
    else
      mode <= next_mode;
  end

  // Mode outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      closed_o <= 1'b0;
      slow_o <= 1'b0;
      const_current_o <= 1'b1;
      ferr_mon_o <= 1'b0;
      align_run_o <= 1'b0;
    end
    else
    begin
      closed_o <= next_mode == fsla_pkg::FSLA_CLOSED ||
                  next_mode == fsla_pkg::FSLA_SLOW;
      slow_o <= next_mode == fsla_pkg::FSLA_SLOW;
      const_current_o <= next_mode != fsla_pkg::FSLA_CLOSED;
      ferr_mon_o <= next_mode == fsla_pkg::FSLA_CLOSED ||
                    next_mode == fsla_pkg::FSLA_SLOW;
      align_run_o <= next_mode == fsla_pkg::FSLA_ALIGN;
    end
  end

  // Brakes must be released by software before alignment is asked
  assign op_grant_o = op_req_i && mode != fsla_pkg::FSLA_ALIGN &&
                      !(mode == fsla_pkg::FSLA_OPEN && next_mode ==
                        fsla_pkg::FSLA_ALIGN);

  // Read port
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      rdata_o <= 16'h0000;
      if (addr_i < 8'(NSENS))
        rdata_o <= {8'h00, mif.q[AW'(addr_i)]};
      else if (addr_i == `FSLA_ADDR_SUBMODE)
        rdata_o <= {8'h00, submode};
      else if (addr_i == `FSLA_ADDR_STATUS)
        rdata_o[`FSLA_STAT_CL] <= op_enabled_i && closed_o;
      else if (addr_i == `FSLA_ADDR_LOOPSEL)
        rdata_o <= {vel_sel_o, pos_sel_o};
      else if (addr_i == `FSLA_ADDR_SPEED)
        rdata_o <= 16'(speed);
      else if (addr_i == `FSLA_ADDR_THRESH)
        rdata_o <= 16'(THRESH);
    end
  end

  closed_status_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_i && addr_i == `FSLA_ADDR_STATUS ##1 1'b1 |->
    rdata_o[`FSLA_STAT_CL] == $past(op_enabled_i && closed_o))
    else $error("status closed bit wrong");
  slow_needs_enc_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    slow_o |-> $past(enc_present && submode[`FSLA_SUB_SLOW]))
    else $error("slow without encoder");
  slow_closed_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    slow_o |-> closed_o)
    else $error("slow without closed");
  setup_sets_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    setup_done_i |=> submode[`FSLA_SUB_CL_EN])
    else $error("setup did not set enable");
  no_grant_align_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    mode == fsla_pkg::FSLA_ALIGN |-> !op_grant_o)
    else $error("granted during align");
  align_once_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    aligned_once |-> mode != fsla_pkg::FSLA_ALIGN)
    else $error("second alignment");
  stand_closed_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $past(speed) == '0 && $past(mode) == fsla_pkg::FSLA_SLOW |->
    mode != fsla_pkg::FSLA_SLOW)
    else $error("slow at standstill");
  enc_wait_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(closed_o) |-> $past(com_abs) || $past(index_seen) ||
    aligned_once)
    else $error("closed before index");
  open_cl_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    closed_o |-> $past(submode[`FSLA_SUB_CL_EN]))
    else $error("closed without enable");
  vel_sel_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    vel_sel_o != `FSLA_SENS_NONE && $stable(vel_sel_o) |->
    vel_sel_o != 8'h00)
    else $error("sensorless chosen");
endmodule : fsla_top

// *** fsla_sensor_model.sv ***
// Behavioural encoder and control cycle source
module fsla_sensor_model #(
  parameter int SPW = 16
) (
  // Clock
  input wire logic sys_clk_i,
  // Controls
  input wire logic [SPW-1:0] step_i,
  input wire logic index_req_i,
  // Sensor outputs
  output logic [SPW-1:0] enc_pos_o,
  output logic cycle_o,
  output logic enc_index_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div = 2'h0;
  initial
  begin
    enc_pos_o = '0;
    cycle_o = 1'b0;
    enc_index_o = 1'b0;
  end
  // Position moves only on cycle pulses, so speed is delta per cycle
  always @(posedge sys_clk_i)
  begin
    div <= div + 2'h1;
    cycle_o <= (div == 2'h3);
    if (div == 2'h3)
      enc_pos_o <= enc_pos_o + step_i;
    enc_index_o <= index_req_i;
  end
endmodule : fsla_sensor_model

// *** tb_feedback_select_loop_activation.sv ***
// Testbench of the feedback selection and loop activation block
`include "fsla_cfg.svh"
module tb_feedback_select_loop_activation;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TH = 40;
  localparam int PL_IDX = 0;
  localparam int PL_SETUP = 1;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] abs_s = 4'h0;
  logic [3:0] enc_s = 4'h0;
  logic [3:0] aln_s = 4'h0;
  logic idx_req = 1'b0;
  logic [15:0] step = 16'h0000;
  logic op_req = 1'b0;
  logic op_en = 1'b0;
  logic setup = 1'b0;
  logic align_done = 1'b0;
  logic [15:0] rdata_o, pos, cur;
  logic [7:0] pos_sel_o, vel_sel_o, com_sel_o;
  logic cyc_p, idx, grant, arun, closed_o, slow_o, cc_o, ferr_o;
  int fails = 0;
  int comparisons = 0;
  fsla_top #(.NSENS(4), .SPW(16), .THRESH(TH)) DUT (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sens_abs_i(abs_s), .sens_enc_i(enc_s),
    .sens_aligned_i(aln_s), .enc_index_i(idx), .enc_pos_i(pos),
    .cycle_i(cyc_p), .op_req_i(op_req), .op_enabled_i(op_en),
    .setup_done_i(setup), .op_grant_o(grant), .align_run_o(arun),
    .align_done_i(align_done), .pos_sel_o(pos_sel_o),
    .vel_sel_o(vel_sel_o), .com_sel_o(com_sel_o), .closed_o(closed_o),
    .slow_o(slow_o), .const_current_o(cc_o), .ferr_mon_o(ferr_o));
  fsla_sensor_model #(.SPW(16)) model (.sys_clk_i(sys_clk_i),
    .step_i(step), .index_req_i(idx_req), .enc_pos_o(pos),
    .cycle_o(cyc_p), .enc_index_o(idx));
  initial
  begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic do_reset();
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    step <= 16'h0000;
    op_req <= 1'b0;
    op_en <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 cur = rdata_o;
  endtask : rd
  task automatic pulse(input int which);
    @(posedge sys_clk_i);
    case (which)
      PL_IDX: idx_req <= 1'b1;
      PL_SETUP: setup <= 1'b1;
      default: align_done <= 1'b1;
    endcase
    @(posedge sys_clk_i);
    idx_req <= 1'b0;
    setup <= 1'b0;
    align_done <= 1'b0;
    cyc(3);
  endtask : pulse
  task automatic t_reset();
    do_reset();
    cyc(1);
    chk("pos_sel", 16'h00ff, pos_sel_o);
    chk("closed", 16'h0000, closed_o);
    chk("const_current", 16'h0001, cc_o);
    rd(`FSLA_ADDR_SUBMODE);
    chk("submode", 16'h0000, cur);
    rd(`FSLA_ADDR_THRESH);
    chk("thresh", TH, cur);
    rd(8'h20);
    chk("unmapped", 16'h0000, cur);
    $display("test reset done");
  endtask : t_reset
  task automatic t_select();
    @(posedge sys_clk_i);
    abs_s <= 4'b0010;
    aln_s <= 4'b0010;
    enc_s <= 4'b0100;
    wr(8'h01, 16'h0006);
    wr(8'h02, 16'h0007);
    wr(8'h03, 16'h0007);
    cyc(3);
    chk("pos_sel", 16'h0002, pos_sel_o);
    chk("vel_sel", 16'h0001, vel_sel_o);
    chk("com_sel", 16'h0001, com_sel_o);
    rd(`FSLA_ADDR_LOOPSEL);
    chk("loopsel", 16'h0102, cur);
    chk("closed", 16'h0000, closed_o);
    wr(`FSLA_ADDR_SUBMODE, 16'h0001);
    op_en <= 1'b1;
    cyc(3);
    chk("closed", 16'h0001, closed_o);
    rd(`FSLA_ADDR_STATUS);
    chk("status", 16'h0001, cur[15]);
    pulse(PL_IDX);
    chk("com_sel", 16'h0002, com_sel_o);
    chk("closed", 16'h0001, closed_o);
    $display("test select done");
  endtask : t_select
  task automatic t_encoder();
    do_reset();
    abs_s <= 4'b0000;
    aln_s <= 4'b0000;
    wr(8'h02, 16'h0004);
    wr(`FSLA_ADDR_SUBMODE, 16'h0001);
    cyc(3);
    chk("com_sel", 16'h0002, com_sel_o);
    chk("closed", 16'h0000, closed_o);
    pulse(PL_IDX);
    chk("closed", 16'h0001, closed_o);
    rd(`FSLA_ADDR_STATUS);
    chk("status", 16'h0000, cur);
    wr(`FSLA_ADDR_SUBMODE, 16'h0000);
    pulse(PL_SETUP);
    rd(`FSLA_ADDR_SUBMODE);
    chk("submode", 16'h0001, cur);
    chk("closed", 16'h0001, closed_o);
    $display("test encoder done");
  endtask : t_encoder
  task automatic t_align();
    do_reset();
    wr(8'h02, 16'h0004);
    @(posedge sys_clk_i);
    op_req <= 1'b1;
    cyc(3);
    chk("align_run", 16'h0001, arun);
    chk("op_grant", 16'h0000, grant);
    pulse(PL_SETUP + 1);
    chk("align_run", 16'h0000, arun);
    chk("op_grant", 16'h0001, grant);
    @(posedge sys_clk_i);
    op_req <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    op_req <= 1'b1;
    cyc(3);
    chk("align_run", 16'h0000, arun);
    do_reset();
    abs_s <= 4'b0010;
    aln_s <= 4'b0010;
    wr(8'h01, 16'h0004);
    wr(`FSLA_ADDR_SUBMODE, 16'h0010);
    op_req <= 1'b1;
    cyc(3);
    chk("align_run", 16'h0001, arun);
    chk("op_grant", 16'h0000, grant);
    $display("test align done");
  endtask : t_align
  task automatic t_slow();
    int n;
    do_reset();
    wr(8'h02, 16'h0007);
    wr(`FSLA_ADDR_SUBMODE, 16'h0081);
    op_en <= 1'b1;
    pulse(PL_IDX);
    chk("slow", 16'h0000, slow_o);
    chk("closed", 16'h0001, closed_o);
    @(posedge sys_clk_i);
    step <= 16'h000a;
    cyc(120);
    chk("slow", 16'h0001, slow_o);
    chk("const_current", 16'h0001, cc_o);
    chk("ferr_mon", 16'h0001, ferr_o);
    rd(`FSLA_ADDR_SPEED);
    chk("speed", 16'h0003, cur);
    // Speed rises until it passes the upper band edge and slow speed ends
    @(posedge sys_clk_i);
    step <= 16'h00c8;
    n = 0;
    while (slow_o !== 1'b0 && n < 600)
    begin
      cyc(1);
      n++;
    end
    chk("slow", 16'h0000, slow_o);
    chk("closed", 16'h0001, closed_o);
    // Decay passes through the slow band and ends at standstill
    @(posedge sys_clk_i);
    step <= 16'h0000;
    cyc(400);
    chk("slow", 16'h0000, slow_o);
    chk("closed", 16'h0001, closed_o);
    rd(`FSLA_ADDR_SPEED);
    chk("speed", 16'h0000, cur);
    $display("test slow done");
  endtask : t_slow
  task automatic wrap_up();
    $display("checks %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    #100000;
    fails++;
    wrap_up();
  end
  initial
  begin
    t_reset();
    t_select();
    t_encoder();
    t_align();
    t_slow();
    wrap_up();
  end
endmodule : tb_feedback_select_loop_activation
